//--- logic/compact_shift_addsub_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module compact_shift_addsub_decoder
    import shift_addsub_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Fetch side
    input wire logic insn_valid,
    input wire logic [INSN_W-1:0] insn,
    // Register file read ports (combinational)
    output logic [REG_IDX_W-1:0] first_src_reg,
    output logic [REG_IDX_W-1:0] second_src_reg,
    input wire logic [WORD_W-1:0] first_src_data,
    input wire logic [WORD_W-1:0] second_src_data,
    // Register file write port
    output logic wr_en,
    output logic [REG_IDX_W-1:0] wr_idx,
    output logic [WORD_W-1:0] wr_data,
    // Status flag write
    output logic flag_wr_en,
    output logic flag_n,
    output logic flag_z,
    output logic flag_c,
    output logic flag_v,
    input wire logic carry_in,
    // Decoded operation
    output logic [2:0] op_code,
    output logic handled
);
    // ========================================
    // Field extraction
    logic is_shift;
    logic is_addsub;
    logic is_hireg;
    logic is_hiadd;
    logic is_himov;
    logic is_loadaddr;
    logic is_spadj;
    logic [1:0] shift_kind;
    logic [SHAMT_W-1:0] shift_amount_imm;
    logic [REG_IDX_W-1:0] small_imm;
    logic [REG_IDX_W-1:0] dst_idx;
    logic use_imm;
    logic do_sub;

    // Group recognition and fields
    always_comb
    begin
        shift_kind = insn[SHOP_LSB +: 2];
        is_shift = (insn[TOP3_LSB +: 3] == SHIFT_SIG) && (shift_kind != SHIFT_RESV_CODE);
        is_addsub = (insn[TOP5_LSB +: 5] == ADDSUB_SIG);
        is_hireg = (insn[TOP6_LSB +: 6] == HIREG_SIG);
        is_hiadd = is_hireg && (insn[HI5_OP_LSB +: 2] == HI5_ADD);
        is_himov = is_hireg && (insn[HI5_OP_LSB +: 2] == HI5_MOV);
        is_loadaddr = (insn[TOP4_LSB +: 4] == LOADADDR_SIG);
        is_spadj = (insn[TOP8_LSB +: 8] == SPADJ_SIG);
        shift_amount_imm = insn[SHAMT_LSB +: SHAMT_W];
        small_imm = insn[RN_LSB +: REG_IDX_W];
        use_imm = insn[IMMSEL_BIT];
        do_sub = insn[ASOP_BIT];
        dst_idx = insn[RD_LSB +: REG_IDX_W];
    end

    // Register file read addresses, low bank only
    always_comb
    begin
        first_src_reg = insn[RS_LSB +: REG_IDX_W];
        second_src_reg = insn[RN_LSB +: REG_IDX_W];
    end

    // ========================================
    // Datapath: shifter and adder
    logic [WORD_W-1:0] shift_res;
    logic [WORD_W-1:0] operand_b;
    logic [WORD_W:0] sum_ext;
    logic [WORD_W-1:0] arith_res;
    logic shift_carry;

    lo_shifter #(
        .W(WORD_W)
    ) u_shifter (
        .val(first_src_data),
        .amt(shift_amount_imm),
        .kind(shift_kind),
        .res(shift_res)
    );

    // Second operand: register or zero-extended immediate
    always_comb
    begin
        if (use_imm)
        begin
            operand_b = {{(WORD_W - REG_IDX_W){1'b0}}, small_imm};
        end
        else
        begin
            operand_b = second_src_data;
        end
    end

    // Add or subtract via two's complement
    always_comb
    begin
        if (do_sub)
        begin
            sum_ext = {1'b0, first_src_data} + {1'b0, ~operand_b} + (WORD_W+1)'(1);
        end
        else
        begin
            sum_ext = {1'b0, first_src_data} + {1'b0, operand_b};
        end
        arith_res = sum_ext[WORD_W-1:0];
    end

    // Shifter carry out; zero amount keeps carry for left and right shifts
    always_comb
    begin
        shift_carry = carry_in;
        unique case (shift_kind)
            SHIFT_LSL_CODE:
            begin
                if (shift_amount_imm != '0)
                begin
                    shift_carry = first_src_data[WORD_W - 32'(shift_amount_imm)];
                end
            end
            SHIFT_LSR_CODE, SHIFT_ASR_CODE:
            begin
                if (shift_amount_imm != '0)
                begin
                    shift_carry = first_src_data[32'(shift_amount_imm) - 1];
                end
            end
            default: shift_carry = carry_in;
        endcase
    end

    // ========================================
    // Expansion into internal operation
    alu_op_e op_nxt;
    logic [WORD_W-1:0] res_nxt;
    logic flags_nxt;
    logic v_nxt;
    logic c_nxt;

    // One decoded operation per halfword
    always_comb
    begin
        op_nxt = none_op;
        res_nxt = '0;
        flags_nxt = 1'b0;
        c_nxt = carry_in;
        v_nxt = 1'b0;
        if (is_shift)
        begin
            unique case (shift_kind)
                SHIFT_LSL_CODE: op_nxt = shift_left_logical_op;
                SHIFT_LSR_CODE: op_nxt = shift_right_logical_op;
                default: op_nxt = shift_right_arith_op;
            endcase
            res_nxt = shift_res;
            flags_nxt = 1'b1;
            c_nxt = shift_carry;
        end
        else if (is_addsub)
        begin
            op_nxt = do_sub ? sub_op : add_op;
            res_nxt = arith_res;
            flags_nxt = 1'b1;
            c_nxt = sum_ext[WORD_W];
            if (do_sub)
            begin
                v_nxt = (first_src_data[WORD_W-1] != operand_b[WORD_W-1])
                    && (arith_res[WORD_W-1] != first_src_data[WORD_W-1]);
            end
            else
            begin
                v_nxt = (first_src_data[WORD_W-1] == operand_b[WORD_W-1])
                    && (arith_res[WORD_W-1] != first_src_data[WORD_W-1]);
            end
        end
        // Add in hi-register, address or stack forms, and hi copy: no flags
        if (is_hiadd || is_loadaddr || is_spadj || is_himov)
        begin
            flags_nxt = 1'b0;
        end
    end

    // ========================================
    // Single-cycle execute stage, matching full-width timing
    logic accept;

    // Halfword taken and belongs to a group handled here
    always_comb
    begin
        accept = insn_valid && (is_shift || is_addsub);
    end

    // Register write strobe, one cycle after the halfword is taken
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            wr_en <= 1'b0;
        end
        else
        begin
            wr_en <= accept;
        end
    end

    // Destination low register index
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            wr_idx <= '0;
        end
        else
        begin
            wr_idx <= dst_idx;
        end
    end

    // Result word, meaningful only while the strobe is high
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            wr_data <= '0;
        end
        else
        begin
            wr_data <= res_nxt;
        end
    end

    // Decoded operation, follows the halfword on every cycle
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            op_code <= 3'(none_op);
        end
        else
        begin
            op_code <= 3'(op_nxt);
        end
    end

    // Pulse for a halfword of a group handled here
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            handled <= 1'b0;
        end
        else
        begin
            handled <= accept;
        end
    end

    // Status flag write strobe, same cycle as result
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            flag_wr_en <= 1'b0;
        end
        else
        begin
            flag_wr_en <= insn_valid && flags_nxt;
        end
    end

    // New flag values, taken by the status word only with the strobe
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            flag_n <= 1'b0;
            flag_z <= 1'b0;
            flag_c <= 1'b0;
            flag_v <= 1'b0;
        end
        else
        begin
            flag_n <= res_nxt[WORD_W-1];
            flag_z <= (res_nxt == '0);
            flag_c <= c_nxt;
            flag_v <= v_nxt;
        end
    end
endmodule // compact_shift_addsub_decoder
`default_nettype wire

//--- logic/shift_addsub_pkg.sv
`default_nettype none
package shift_addsub_pkg;
    // ========================================
    // Halfword field layout
    localparam int unsigned INSN_W = 16;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned REG_IDX_W = 3;
    localparam int unsigned HI_REG_IDX_W = 4;
    localparam int unsigned SHAMT_W = 5;
    localparam int unsigned RD_LSB = 0;
    localparam int unsigned RS_LSB = 3;
    localparam int unsigned RN_LSB = 6;
    localparam int unsigned SHAMT_LSB = 6;
    localparam int unsigned SHOP_LSB = 11;
    localparam int unsigned ASOP_BIT = 9;
    localparam int unsigned IMMSEL_BIT = 10;
    localparam int unsigned TOP3_LSB = 13;
    localparam int unsigned TOP5_LSB = 11;
    localparam int unsigned TOP6_LSB = 10;
    localparam int unsigned TOP4_LSB = 12;
    localparam int unsigned TOP8_LSB = 8;
    localparam int unsigned HI5_OP_LSB = 8;
    // ========================================
    // Group signatures
    localparam logic [2:0] SHIFT_SIG = 3'h0;
    localparam logic [4:0] ADDSUB_SIG = 5'h03;
    localparam logic [5:0] HIREG_SIG = 6'h11;
    localparam logic [3:0] LOADADDR_SIG = 4'hA;
    localparam logic [7:0] SPADJ_SIG = 8'hB0;
    localparam logic [1:0] HI5_ADD = 2'h0;
    localparam logic [1:0] HI5_MOV = 2'h2;
    // ========================================
    // Shift opcodes
    localparam logic [1:0] SHIFT_LSL_CODE = 2'h0;
    localparam logic [1:0] SHIFT_LSR_CODE = 2'h1;
    localparam logic [1:0] SHIFT_ASR_CODE = 2'h2;
    localparam logic [1:0] SHIFT_RESV_CODE = 2'h3;
    // ========================================
    // Execution
    localparam int unsigned EXEC_CYCLES = 1;
    typedef enum logic [2:0] {
        shift_left_logical_op,
        shift_right_logical_op,
        shift_right_arith_op,
        add_op,
        sub_op,
        none_op
    } alu_op_e;
endpackage
`default_nettype wire

//--- logic/lo_shifter.sv
`timescale 1ns/100ps
`default_nettype none
module lo_shifter
    import shift_addsub_pkg::*;
#(
    parameter int unsigned W = 32
)(
    // Operand
    input wire logic [W-1:0] val,
    input wire logic [SHAMT_W-1:0] amt,
    input wire logic [1:0] kind,
    // Result
    output logic [W-1:0] res
);
    // ========================================
    // Barrel shift by immediate
    always_comb
    begin
        unique case (kind)
            SHIFT_LSL_CODE: res = val << amt;
            SHIFT_LSR_CODE: res = val >> amt;
            SHIFT_ASR_CODE: res = W'($signed(val) >>> amt);
            default: res = val;
        endcase
    end
endmodule // lo_shifter
`default_nettype wire

//--- dv/lo_regfile_model.sv
`timescale 1ns/100ps
`default_nettype none
// ========================================
// Low register bank with fixed contents
module lo_regfile_model
    import shift_addsub_pkg::*;
(
    // Read indices
    input wire logic [REG_IDX_W-1:0] first_src_reg,
    input wire logic [REG_IDX_W-1:0] second_src_reg,
    // Read data
    output logic [WORD_W-1:0] first_src_data,
    output logic [WORD_W-1:0] second_src_data
);
    // Distinct value per register, sign bit differs between them
    assign first_src_data = 32'h9ABC_0135 * (32'(first_src_reg) + 32'h1);
    assign second_src_data = 32'h9ABC_0135 * (32'(second_src_reg) + 32'h1);
endmodule // lo_regfile_model
`default_nettype wire

//--- dv/compact_shift_addsub_decoder_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module compact_shift_addsub_decoder_assertions
    import shift_addsub_pkg::*;
(
    // Clock, reset and fetch
    input wire logic core_clk,
    input wire logic srst,
    input wire logic insn_valid,
    input wire logic [INSN_W-1:0] insn,
    // Register file
    input wire logic [REG_IDX_W-1:0] first_src_reg,
    input wire logic [REG_IDX_W-1:0] second_src_reg,
    input wire logic [WORD_W-1:0] first_src_data,
    input wire logic [WORD_W-1:0] second_src_data,
    input wire logic wr_en,
    input wire logic [REG_IDX_W-1:0] wr_idx,
    input wire logic [WORD_W-1:0] wr_data,
    // Flags and status
    input wire logic flag_wr_en,
    input wire logic flag_n,
    input wire logic flag_z,
    input wire logic flag_c,
    input wire logic flag_v,
    input wire logic carry_in,
    input wire logic [2:0] op_code,
    input wire logic handled
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // Group recognition from the top bits
    wire logic is_shift = insn[15:13] == SHIFT_SIG && insn[12:11] != 2'h3;
    wire logic is_addsub = insn[15:11] == ADDSUB_SIG;
    // ========================================
    // Steps of a transfer
    sequence take_shift;
        insn_valid && is_shift;
    endsequence
    sequence take_addsub;
        insn_valid && is_addsub;
    endsequence
    sequence write_out;
        wr_en && flag_wr_en && handled && wr_idx == $past(insn[2:0]);
    endsequence
    a_shift_answer: assert property (take_shift |=> write_out)
        else $error("shift write missing");
    a_addsub_answer: assert property (take_addsub |=> write_out)
        else $error("add/sub write missing");
    a_other_quiet: assert property (insn_valid && !is_shift && !is_addsub
        |=> !wr_en && !flag_wr_en && !handled) else $error("other group answered");
    a_lo_read_idx: assert property (insn_valid && is_addsub
        |-> first_src_reg == insn[5:3] && second_src_reg == insn[8:6])
        else $error("read index wrong");
    a_shift_left: assert property (take_shift ##0 insn[12:11] == 2'h0
        |=> wr_data == $past(first_src_data) << $past(insn[10:6])) else $error("lsl wrong");
    a_add_regs: assert property (take_addsub ##0 insn[10:9] == 2'h0
        |=> wr_data == $past(first_src_data) + $past(second_src_data)
        && op_code == 3'(add_op)) else $error("add wrong");
    a_add_imm: assert property (take_addsub ##0 insn[10:9] == 2'h2
        |=> wr_data == $past(first_src_data) + 32'($past(insn[8:6]))) else $error("addi wrong");
    a_sub_regs: assert property (take_addsub ##0 insn[10:9] == 2'h1
        |=> wr_data == $past(first_src_data) - $past(second_src_data)
        && op_code == 3'(sub_op)) else $error("sub wrong");
    a_sub_imm: assert property (take_addsub ##0 insn[10:9] == 2'h3
        |=> wr_data == $past(first_src_data) - 32'($past(insn[8:6]))) else $error("subi wrong");
    a_shift_right: assert property (take_shift ##0 insn[12:11] == 2'h1
        |=> wr_data == $past(first_src_data) >> $past(insn[10:6])) else $error("lsr wrong");
    a_shift_arith: assert property (take_shift ##0 insn[12:11] == 2'h2
        |=> wr_data == 32'($signed($past(first_src_data)) >>> $past(insn[10:6])))
        else $error("asr wrong");
    a_shift_carry: assert property (take_shift ##0 insn[12:6] == 7'h0
        |=> flag_c == $past(carry_in)) else $error("carry not kept");
    a_flag_value: assert property (flag_wr_en
        |-> flag_z == (wr_data == 32'h0) && flag_n == wr_data[31]) else $error("flags wrong");
endmodule // compact_shift_addsub_decoder_assertions
bind compact_shift_addsub_decoder compact_shift_addsub_decoder_assertions chk_inst (.core_clk,
    .srst, .insn_valid, .insn, .first_src_reg, .second_src_reg, .first_src_data,
    .second_src_data, .wr_en, .wr_idx, .wr_data, .flag_wr_en, .flag_n, .flag_z, .flag_c,
    .flag_v, .carry_in, .op_code, .handled);
`default_nettype wire

//--- dv/compact_shift_addsub_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none
module compact_shift_addsub_decoder_tb;
    import shift_addsub_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic insn_valid = 1'b0;
    logic [15:0] insn = 16'h0;
    logic carry_in = 1'b0;
    logic [2:0] rs_idx, rn_idx, wr_idx, op_code;
    logic [31:0] rs_data, rn_data, wr_data;
    logic wr_en, flag_wr_en, flag_n, flag_z, flag_c, flag_v, handled;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    // Clock and hang guard
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            fail_count++;
            print_verdict();
        end
    end
    compact_shift_addsub_decoder compact_shift_addsub_decoder_inst (.core_clk(core_clk),
        .srst(srst), .insn_valid(insn_valid), .insn(insn), .first_src_reg(rs_idx),
        .second_src_reg(rn_idx), .first_src_data(rs_data), .second_src_data(rn_data),
        .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data), .flag_wr_en(flag_wr_en),
        .flag_n(flag_n), .flag_z(flag_z), .flag_c(flag_c), .flag_v(flag_v),
        .carry_in(carry_in), .op_code(op_code), .handled(handled));
    lo_regfile_model lo_regfile_model_inst (.first_src_reg(rs_idx), .second_src_reg(rn_idx),
        .first_src_data(rs_data), .second_src_data(rn_data));
    // ========================================
    // Shared helpers
    function automatic logic [31:0] rv(input int i);
        return 32'h9ABC_0135 * 32'(i + 1);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    // One instruction, answer judged one cycle later
    task automatic issue(input logic [15:0] h, input logic [31:0] exp, input logic wr);
        @(posedge core_clk);
        insn <= h;
        insn_valid <= 1'b1;
        @(posedge core_clk);
        insn_valid <= 1'b0;
        #1;
        chk(32'({wr_en, flag_wr_en, handled}), 32'({3{wr}}));
        if (wr)
        begin
            chk(wr_data, exp);
            chk(32'(wr_idx), 32'(h[2:0]));
            chk(32'({flag_n, flag_z}), 32'({exp[31], exp == 32'h0}));
        end
    endtask
    task automatic print_verdict;
        if (fail_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ========================================
    // Scenarios
    task automatic sc_shifts;
        logic [4:0] a;
        logic [31:0] s, e;
        for (int k = 0; k < 3; k++)
        begin
            a = 5'h1F - 5'(2 * k);
            s = rv(k);
            e = (k == 0) ? s << a : (k == 1) ? s >> a : 32'($signed(s) >>> a);
            issue({3'h0, 2'(k), a, 3'(k), 3'(k + 4)}, e, 1'b1);
            chk(32'(op_code), 32'(k));
        end
    endtask
    task automatic sc_addsub;
        logic [31:0] n, e;
        for (int k = 0; k < 4; k++)
        begin
            n = k[1] ? 32'h7 : rv(7);
            e = k[0] ? rv(5) - n : rv(5) + n;
            issue({5'h03, 2'(k), 3'h7, 3'h5, 3'(k)}, e, 1'b1);
        end
        issue({5'h03, 2'h1, 3'h2, 3'h2, 3'h3}, 32'h0, 1'b1);
        chk(32'({flag_c, flag_v}), 32'h2);
    endtask
    task automatic sc_flags;
        @(posedge core_clk);
        carry_in <= 1'b1;
        issue(16'h0008, rv(1), 1'b1);
        chk(32'(flag_c), 32'h1);
        @(posedge core_clk);
        carry_in <= 1'b0;
        issue({3'h0, 2'h1, 5'h01, 3'h0, 3'h2}, rv(0) >> 1, 1'b1);
        chk(32'(flag_c), 32'h1);
        issue({5'h03, 2'h0, 3'h2, 3'h0, 3'h1}, rv(0) + rv(2), 1'b1);
        chk(32'({flag_c, flag_v}), 32'h3);
        issue({5'h03, 2'h1, 3'h0, 3'h1, 3'h3}, rv(1) - rv(0), 1'b1);
        chk(32'({flag_c, flag_v}), 32'h1);
    endtask
    task automatic sc_quiet;
        logic [15:0] q [4] = '{16'h4488, 16'h4688, 16'hA123, 16'hB005};
        foreach (q[i])
            issue(q[i], 32'h0, 1'b0);
    endtask
    initial
    begin
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        #1;
        chk(32'({wr_en, flag_wr_en, handled, op_code}), 32'h5);
        sc_shifts();
        sc_addsub();
        sc_flags();
        sc_quiet();
        print_verdict();
    end
endmodule // compact_shift_addsub_decoder_tb
`default_nettype wire
